// >>> verilog/otpg_pkg.sv
package otpg_pkg;

	localparam int unsigned SAMPLE_W   = 16;
	localparam int unsigned USER_WORDS = 4;
	localparam int unsigned USER_BYTES = 8;

	typedef logic [SAMPLE_W-1:0]                 otpg_sample_t;
	typedef logic [USER_WORDS-1:0][SAMPLE_W-1:0] otpg_user_t;

	typedef struct packed {
		otpg_sample_t i;
		otpg_sample_t q;
	} otpg_pair_s;

	typedef enum logic [3:0] {
		OTPG_MODE_NORMAL   = 4'b0000,
		OTPG_MODE_MIDSCALE = 4'b0001,
		OTPG_MODE_POS_FULL = 4'b0010,
		OTPG_MODE_NEG_FULL = 4'b0011,
		OTPG_MODE_CHECKER  = 4'b0100,
		OTPG_MODE_PRS_LONG = 4'b0101,
		OTPG_MODE_PRS_SHRT = 4'b0110,
		OTPG_MODE_TOGGLE   = 4'b0111,
		OTPG_MODE_USER     = 4'b1000,
		OTPG_MODE_RAMP     = 4'b1111
	} otpg_mode_e;

	typedef struct packed {
		logic       user_single;
		logic       long_sequence_hold;
		logic       short_sequence_hold;
		otpg_mode_e mode;
	} otpg_ctrl_s;

	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_TEST_ENABLE = 12'h0347;
	localparam logic [11:0] IDX_CONTROL     = 12'h0550;
	localparam logic [11:0] IDX_USER1_LOW   = 12'h0551;
	localparam logic [11:0] IDX_USER1_HIGH  = 12'h0552;
	localparam logic [11:0] IDX_USER2_LOW   = 12'h0553;
	localparam logic [11:0] IDX_USER2_HIGH  = 12'h0554;
	localparam logic [11:0] IDX_USER3_LOW   = 12'h0555;
	localparam logic [11:0] IDX_USER3_HIGH  = 12'h0556;
	localparam logic [11:0] IDX_USER4_LOW   = 12'h0557;
	localparam logic [11:0] IDX_USER4_HIGH  = 12'h0558;
	localparam logic [11:0] IDX_STATUS      = 12'h055B;

	localparam int unsigned TEST_EN_I_BIT   = 0;
	localparam int unsigned TEST_EN_Q_BIT   = 2;
	localparam int unsigned CTRL_SINGLE_BIT = 7;
	localparam int unsigned CTRL_LONG_BIT   = 5;
	localparam int unsigned CTRL_SHORT_BIT  = 4;
	localparam int unsigned CTRL_MODE_LSB   = 0;

	localparam logic [7:0] TEST_ENABLE_MASK = 8'h05;
	localparam logic [7:0] CONTROL_MASK     = 8'hBF;
	localparam logic [7:0] TEST_ENABLE_RST  = 8'h00;
	localparam logic [7:0] CONTROL_RST      = 8'h00;
	localparam logic [7:0] USER_BYTE_RST    = 8'h00;

	localparam otpg_sample_t PAT_MIDSCALE  = 16'h0000;
	localparam otpg_sample_t PAT_POS_FULL  = 16'h7FFF;
	localparam otpg_sample_t PAT_NEG_FULL  = 16'h8000;
	localparam otpg_sample_t PAT_CHECKER_A = 16'h5555;
	localparam otpg_sample_t PAT_CHECKER_B = 16'hAAAA;
	localparam otpg_sample_t PAT_ONES      = 16'hFFFF;
	localparam otpg_sample_t PAT_ZERO      = 16'h0000;

	localparam int unsigned LONG_W    = 23;
	localparam int unsigned LONG_TAP  = 18;
	localparam int unsigned SHORT_W   = 9;
	localparam int unsigned SHORT_TAP = 5;

endpackage : otpg_pkg

// >>> verilog/otpg_sequence.sv
module otpg_sequence #(
	parameter int unsigned W   = 9,
	parameter int unsigned TAP = 5
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  hold_i,
	input  wire logic                  step_i,
	output otpg_pkg::otpg_sample_t     word_o
);
	import otpg_pkg::*;

	logic [W-1:0] state;
	logic [W-1:0] next_state;
	otpg_sample_t word;
	otpg_sample_t next_word;
	logic         fb;

	always_comb begin
		fb         = state[W-1] ^ state[TAP-1];
		next_state = state;
		next_word  = word;
		if (hold_i) begin
			next_state = '1;
			next_word  = PAT_ZERO;
		end else if (step_i) begin
			next_state = {state[W-2:0], fb};
			next_word  = {word[SAMPLE_W-2:0], fb};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= '1;
			word  <= PAT_ZERO;
		end else begin
			state <= next_state;
			word  <= next_word;
		end
	end

	assign word_o = word;

endmodule : otpg_sequence

// >>> verilog/otpg_pattern.sv
module otpg_pattern (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  otpg_pkg::otpg_ctrl_s       ctrl_i,
	input  otpg_pkg::otpg_user_t       user_i,
	input  wire logic                  step_i,
	output otpg_pkg::otpg_sample_t     pattern_o,
	output logic                       user_done_o,
	output logic [1:0]                 user_index_o
);
	import otpg_pkg::*;

	logic         phase;
	logic         next_phase;
	otpg_sample_t ramp;
	otpg_sample_t next_ramp;
	logic [1:0]   index;
	logic [1:0]   next_index;
	logic         done;
	logic         next_done;
	otpg_sample_t long_word;
	otpg_sample_t short_word;

	otpg_sequence #(.W(LONG_W), .TAP(LONG_TAP)) u_long (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.hold_i (ctrl_i.long_sequence_hold),
		.step_i (step_i),
		.word_o (long_word)
	);

	otpg_sequence #(.W(SHORT_W), .TAP(SHORT_TAP)) u_short (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.hold_i (ctrl_i.short_sequence_hold),
		.step_i (step_i),
		.word_o (short_word)
	);

	always_comb begin
		next_phase = phase;
		next_ramp  = ramp;
		next_index = index;
		next_done  = done;
		if (step_i) begin
			next_phase = ~phase;
		end
		if (ctrl_i.mode != OTPG_MODE_RAMP) begin
			next_ramp = PAT_ZERO;
		end else if (step_i) begin
			next_ramp = ramp + 16'h0001;
		end
		if (ctrl_i.mode != OTPG_MODE_USER) begin
			next_index = 2'b00;
			next_done  = 1'b0;
		end else if (!ctrl_i.user_single) begin
			// Repeat mode never stays stopped after a single pass
			next_done = 1'b0;
			if (step_i) begin
				next_index = index + 2'b01;
			end
		end else if (step_i && !done) begin
			next_index = index + 2'b01;
			if (index == 2'b11) begin
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase <= 1'b0;
			ramp  <= PAT_ZERO;
			index <= 2'b00;
			done  <= 1'b0;
		end else begin
			phase <= next_phase;
			ramp  <= next_ramp;
			index <= next_index;
			done  <= next_done;
		end
	end

	always_comb begin
		unique case (ctrl_i.mode)
			OTPG_MODE_NORMAL:   pattern_o = PAT_ZERO;
			OTPG_MODE_MIDSCALE: pattern_o = PAT_MIDSCALE;
			OTPG_MODE_POS_FULL: pattern_o = PAT_POS_FULL;
			OTPG_MODE_NEG_FULL: pattern_o = PAT_NEG_FULL;
			OTPG_MODE_CHECKER: begin
				pattern_o = phase ? PAT_CHECKER_B : PAT_CHECKER_A;
			end
			OTPG_MODE_PRS_LONG: pattern_o = long_word;
			OTPG_MODE_PRS_SHRT: pattern_o = short_word;
			OTPG_MODE_TOGGLE: begin
				pattern_o = phase ? PAT_ZERO : PAT_ONES;
			end
			OTPG_MODE_USER: begin
				pattern_o = user_i[index];
				if (done && ctrl_i.user_single) begin
					pattern_o = PAT_ZERO;
				end
			end
			OTPG_MODE_RAMP:     pattern_o = ramp;
			default:            pattern_o = PAT_ZERO;
		endcase
	end

	assign user_done_o  = done;
	assign user_index_o = index;

	a_ramp_step: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(ctrl_i.mode == OTPG_MODE_RAMP && step_i) ##1
		(ctrl_i.mode == OTPG_MODE_RAMP)
		|-> ramp == $past(ramp) + 16'h0001
	) else $error("ramp did not advance by one");

	a_user_wrap: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(ctrl_i.mode == OTPG_MODE_USER && !ctrl_i.user_single
			&& index == 2'b11 && step_i)
		|=> index == 2'b00 && !done
	) else $error("user words did not repeat");

	a_user_single: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(ctrl_i.mode == OTPG_MODE_USER && ctrl_i.user_single
			&& index == 2'b11 && step_i && !done)
		##1 (ctrl_i.mode == OTPG_MODE_USER) |-> done
	) else $error("single user pass did not stop");

	a_long_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ctrl_i.long_sequence_hold |=> long_word == PAT_ZERO
	) else $error("long sequence ran while held");

	a_short_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ctrl_i.short_sequence_hold |=> short_word == PAT_ZERO
	) else $error("short sequence ran while held");

endmodule : otpg_pattern

// >>> verilog/otpg_top.sv
// Functional notes
// - Quadrature test enable set swaps Q samples for B/D patterns.
// - In-phase test enable set swaps I samples for A/C patterns.
// - The 4-bit selector picks normal, fixed, checker, PRS, toggle, user, ramp.
// - User mode sends the words in order, repeating or once only.
// - The long sequence hold bit keeps the long generator in reset.
// - The short sequence hold bit keeps the short generator in reset.
// - Each user word is a low byte then a high byte, reset to zero.
// - The fourth user word sits in the two addresses after the third.
//
// Design decision made here: the Wishbone register port.
module otpg_top (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [13:0]           wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic                  sample_valid_i,
	input  otpg_pkg::otpg_pair_s       sample_i,
	output logic                       sample_valid_o,
	output otpg_pkg::otpg_pair_s       sample_o
);
	import otpg_pkg::*;

	// Register file state
	logic [7:0]  test_enable;
	logic [7:0]  next_test_enable;
	logic [7:0]  control;
	logic [7:0]  next_control;
	logic [7:0]  user_bytes [USER_BYTES];
	logic [7:0]  next_user_bytes [USER_BYTES];
	logic        ack;
	logic        next_ack;
	logic [31:0] dat;
	logic [31:0] next_dat;

	// Output sample state
	otpg_pair_s  out_pair;
	otpg_pair_s  next_out_pair;
	logic        out_valid;
	logic        next_out_valid;

	logic        req;
	logic        wr_now;
	logic [11:0] idx;
	logic [7:0]  rd_byte;
	logic [7:0]  status;
	otpg_ctrl_s  ctrl;
	otpg_user_t  user_words;
	otpg_sample_t pat_i;
	otpg_sample_t pat_q;
	logic        done_i;
	logic        done_q;
	logic [1:0]  index_i;
	logic [1:0]  index_q;
	logic        en_i;
	logic        en_q;
	logic        mode_on;

	assign req    = wb_cyc_i && wb_stb_i;
	// Write lands on the edge where the master sees ack
	assign wr_now = req && ack && wb_we_i && wb_sel_i[0];
	assign idx    = wb_adr_i[13:2];

	assign ctrl = '{
		user_single:         control[CTRL_SINGLE_BIT],
		long_sequence_hold:  control[CTRL_LONG_BIT],
		short_sequence_hold: control[CTRL_SHORT_BIT],
		mode:                otpg_mode_e'(control[CTRL_MODE_LSB +: 4])
	};

	always_comb begin
		for (int k = 0; k < USER_WORDS; k++) begin
			user_words[k] = {user_bytes[2*k+1], user_bytes[2*k]};
		end
	end

	assign status = {2'b00, done_q, done_i, index_q, index_i};

	always_comb begin
		unique case (idx)
			IDX_TEST_ENABLE: rd_byte = test_enable;
			IDX_CONTROL:     rd_byte = control;
			IDX_USER1_LOW:   rd_byte = user_bytes[0];
			IDX_USER1_HIGH:  rd_byte = user_bytes[1];
			IDX_USER2_LOW:   rd_byte = user_bytes[2];
			IDX_USER2_HIGH:  rd_byte = user_bytes[3];
			IDX_USER3_LOW:   rd_byte = user_bytes[4];
			IDX_USER3_HIGH:  rd_byte = user_bytes[5];
			IDX_USER4_LOW:   rd_byte = user_bytes[6];
			IDX_USER4_HIGH:  rd_byte = user_bytes[7];
			IDX_STATUS:      rd_byte = status;
			default:         rd_byte = 8'h00;
		endcase
	end

	always_comb begin
		next_test_enable = test_enable;
		next_control     = control;
		for (int k = 0; k < USER_BYTES; k++) begin
			next_user_bytes[k] = user_bytes[k];
		end
		next_ack = req && !ack;
		next_dat = 32'h0000_0000;
		if (req && !ack && !wb_we_i) begin
			next_dat = {24'h00_0000, rd_byte};
		end
		if (wr_now) begin
			unique case (idx)
				IDX_TEST_ENABLE: begin
					next_test_enable = wb_dat_i[7:0] & TEST_ENABLE_MASK;
				end
				IDX_CONTROL: begin
					next_control = wb_dat_i[7:0] & CONTROL_MASK;
				end
				IDX_USER1_LOW:  next_user_bytes[0] = wb_dat_i[7:0];
				IDX_USER1_HIGH: next_user_bytes[1] = wb_dat_i[7:0];
				IDX_USER2_LOW:  next_user_bytes[2] = wb_dat_i[7:0];
				IDX_USER2_HIGH: next_user_bytes[3] = wb_dat_i[7:0];
				IDX_USER3_LOW:  next_user_bytes[4] = wb_dat_i[7:0];
				IDX_USER3_HIGH: next_user_bytes[5] = wb_dat_i[7:0];
				IDX_USER4_LOW:  next_user_bytes[6] = wb_dat_i[7:0];
				IDX_USER4_HIGH: next_user_bytes[7] = wb_dat_i[7:0];
				default: begin
					next_test_enable = test_enable;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			test_enable <= TEST_ENABLE_RST;
			control     <= CONTROL_RST;
			for (int k = 0; k < USER_BYTES; k++) begin
				user_bytes[k] <= USER_BYTE_RST;
			end
			ack <= 1'b0;
			dat <= 32'h0000_0000;
		end else begin
			test_enable <= next_test_enable;
			control     <= next_control;
			for (int k = 0; k < USER_BYTES; k++) begin
				user_bytes[k] <= next_user_bytes[k];
			end
			ack <= next_ack;
			dat <= next_dat;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = dat;

	// A/C block serves I, B/D block serves Q
	otpg_pattern u_block_ac (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.ctrl_i       (ctrl),
		.user_i       (user_words),
		.step_i       (sample_valid_i),
		.pattern_o    (pat_i),
		.user_done_o  (done_i),
		.user_index_o (index_i)
	);

	otpg_pattern u_block_bd (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.ctrl_i       (ctrl),
		.user_i       (user_words),
		.step_i       (sample_valid_i),
		.pattern_o    (pat_q),
		.user_done_o  (done_q),
		.user_index_o (index_q)
	);

	assign mode_on = ctrl.mode != OTPG_MODE_NORMAL;
	assign en_i    = test_enable[TEST_EN_I_BIT] && mode_on;
	assign en_q    = test_enable[TEST_EN_Q_BIT] && mode_on;

	always_comb begin
		next_out_pair  = out_pair;
		next_out_valid = sample_valid_i;
		if (sample_valid_i) begin
			next_out_pair.i = en_i ? pat_i : sample_i.i;
			next_out_pair.q = en_q ? pat_q : sample_i.q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_pair  <= '0;
			out_valid <= 1'b0;
		end else begin
			out_pair  <= next_out_pair;
			out_valid <= next_out_valid;
		end
	end

	assign sample_o       = out_pair;
	assign sample_valid_o = out_valid;

	a_q_passthru: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i && !test_enable[TEST_EN_Q_BIT]
		|=> sample_valid_o && sample_o.q == $past(sample_i.q)
	) else $error("Q sample altered with test disabled");

	a_q_pattern: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i && en_q |=> sample_o.q == $past(pat_q)
	) else $error("Q sample not replaced by pattern");

	a_i_passthru: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i && !test_enable[TEST_EN_I_BIT]
		|=> sample_valid_o && sample_o.i == $past(sample_i.i)
	) else $error("I sample altered with test disabled");

	a_i_pattern: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i && en_i |=> sample_o.i == $past(pat_i)
	) else $error("I sample not replaced by pattern");

	a_fixed_full: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i && en_i && ctrl.mode == OTPG_MODE_POS_FULL
		|=> sample_o.i == PAT_POS_FULL
	) else $error("positive full scale code wrong");

	a_ack_pulse: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o
	) else $error("ack held longer than one cycle");

	a_byte_store: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_now && idx == IDX_USER1_HIGH
		|=> user_words[0][15:8] == $past(wb_dat_i[7:0])
	) else $error("user word high byte not stored");

	a_word4_low: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_now && idx == IDX_USER4_LOW
		|=> user_words[3][7:0] == $past(wb_dat_i[7:0])
	) else $error("fourth user word low byte not stored");

	a_user_reset: assert property (
		@(posedge clk_i)
		rst_i |=> user_words == '0
	) else $error("user words not cleared by reset");

	a_q_mode_off: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i && ctrl.mode == OTPG_MODE_NORMAL
		|=> sample_o.q == $past(sample_i.q)
	) else $error("Q sample altered in normal operation");

	a_i_mode_off: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i && ctrl.mode == OTPG_MODE_NORMAL
		|=> sample_o.i == $past(sample_i.i)
	) else $error("I sample altered in normal operation");

	a_neg_full: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i && en_q && ctrl.mode == OTPG_MODE_NEG_FULL
		|=> sample_o.q == PAT_NEG_FULL
	) else $error("negative full scale code wrong");

	a_ack_answer: assert property (
		@(posedge clk_i) disable iff (rst_i)
		req && !wb_ack_o |=> wb_ack_o
	) else $error("bus request not acknowledged next cycle");

	a_dat_idle: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000
	) else $error("read data driven outside an answer");

	a_valid_delay: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sample_valid_i |=> sample_valid_o
	) else $error("output strobe missing after input sample");

	a_valid_quiet: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!sample_valid_i |=> !sample_valid_o
	) else $error("output strobe without input sample");

endmodule : otpg_top

// >>> sim/otpg_source.sv
module otpg_source (
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	input  wire logic           run_i,
	output logic                valid_o,
	output otpg_pkg::otpg_pair_s sample_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import otpg_pkg::*;

	logic [31:0] r;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Random gaps; data is inverted whenever no sample is offered
	always @(posedge clk_i) begin
		if (rst_i) begin
			r <= 32'he881_af45;
			valid_o <= 1'b0;
			sample_o <= '0;
		end else begin
			r <= lfsr(r);
			valid_o <= run_i && (r[2:0] != 3'h0);
			sample_o <= (run_i && r[2:0] != 3'h0) ? r : ~sample_o;
		end
	end
endmodule : otpg_source

// >>> sim/output_test_pattern_generator_tb_top.sv
module output_test_pattern_generator_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import otpg_pkg::*;

	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, run;
	logic [13:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q, rnd;
	logic        wb_ack_o, sample_valid_i, sample_valid_o;
	otpg_pair_s  sample_i, sample_o, pin;
	logic [7:0]  m, en, ub[8];
	logic [22:0] ls = '1;
	logic [8:0]  ss = '1;
	logic [15:0] lw = 16'h0000, sw = 16'h0000;
	int          error_cnt, checks, cnt, rc, ui, nz, seen, i;

	otpg_top otpg_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.sample_valid_i, .sample_i, .sample_valid_o, .sample_o);
	otpg_source otpg_source_inst (.clk_i, .rst_i, .run_i(run),
		.valid_o(sample_valid_i), .sample_o(sample_i));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	task automatic wb(input logic we, input logic [11:0] idx,
		input logic [7:0] d, input logic s0);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= {3'b000, s0};
		wb_dat_i <= {24'h00_0000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			tally_and_finish();
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic rd(input logic [11:0] idx, input logic [7:0] e);
		wb(1'b0, idx, 8'h00, 1'b1);
		chk(q, {24'h00_0000, e});
	endtask : rd

	// Program lanes and mode, then let the source run for n samples
	task automatic stream(input logic [7:0] e, input logic [7:0] c, input int n);
		int k;
		wb(1'b1, IDX_TEST_ENABLE, e, 1'b1);
		wb(1'b1, IDX_CONTROL, c, 1'b1);
		en = e;
		m = c;
		rc = 0;
		ui = 0;
		seen = 0;
		run <= 1'b1;
		for (k = 0; k < 400 && seen < n; k++)
			@(posedge clk_i);
		if (seen < n) begin
			error_cnt++;
			tally_and_finish();
		end
		run <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : stream

	// Reference model of both lanes, checked at every output sample
	always @(posedge clk_i) begin
		logic [15:0] p, ei, eq;
		if (!rst_i && sample_valid_o === 1'b1) begin
			seen++;
			// Hold bits pin each generator to its seed
			if (m[5]) begin
				ls = '1;
				lw = 16'h0000;
			end
			if (m[4]) begin
				ss = '1;
				sw = 16'h0000;
			end
			case (m[3:0])
				4'h2: p = 16'h7FFF;
				4'h3: p = 16'h8000;
				4'h4: p = cnt[0] ? 16'hAAAA : 16'h5555;
				4'h5: p = lw;
				4'h6: p = sw;
				4'h7: p = cnt[0] ? 16'h0000 : 16'hFFFF;
				4'h8: p = (m[7] && ui > 3) ? 16'h0000 :
					{ub[2 * (ui % 4) + 1], ub[2 * (ui % 4)]};
				4'hF: p = rc[15:0];
				default: p = 16'h0000;
			endcase
			if ((m[3:0] == 4'h5 && !m[5]) || (m[3:0] == 4'h6 && !m[4])) begin
				nz += int'(sample_o != '0);
			end
			ei = (m[3:0] == 4'h0 || !en[0]) ? pin.i : p;
			eq = (m[3:0] == 4'h0 || !en[2]) ? pin.q : p;
			chk(32'(sample_o.i), 32'(ei));
			chk(32'(sample_o.q), 32'(eq));
			// Each generator steps on every sample in every mode unless its hold bit is set
			if (!m[5]) begin
				lw = {lw[14:0], ls[22] ^ ls[17]};
				ls = {ls[21:0], ls[22] ^ ls[17]};
			end
			if (!m[4]) begin
				sw = {sw[14:0], ss[8] ^ ss[4]};
				ss = {ss[7:0], ss[8] ^ ss[4]};
			end
			cnt++;
			rc++;
			ui++;
		end
		if (sample_valid_i === 1'b1)
			pin <= sample_i;
	end

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = '0;
		wb_sel_i = '0;
		wb_dat_i = '0;
		run = 1'b0;
		m = '0;
		en = '0;
		rnd = 32'he881_af45;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(IDX_TEST_ENABLE, 8'h00);
		rd(IDX_CONTROL, 8'h00);
		for (i = 0; i < 8; i++)
			rd(12'(IDX_USER1_LOW + i), 8'h00);
		for (i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			ub[i] = rnd[7:0];
			wb(1'b1, 12'(IDX_USER1_LOW + i), ub[i], 1'b1);
		end
		for (i = 0; i < 8; i++)
			rd(12'(IDX_USER1_LOW + i), ub[i]);
		wb(1'b1, IDX_USER1_LOW, ~ub[0], 1'b0);
		rd(IDX_USER1_LOW, ub[0]);
		wb(1'b1, 12'h055C, 8'hFF, 1'b1);
		rd(12'h055C, 8'h00);
		wb(1'b1, IDX_TEST_ENABLE, 8'hFF, 1'b1);
		rd(IDX_TEST_ENABLE, 8'h05);
		wb(1'b1, IDX_CONTROL, 8'hFF, 1'b1);
		rd(IDX_CONTROL, 8'hBF);
		wb(1'b1, IDX_STATUS, 8'hFF, 1'b1);
		rd(IDX_STATUS, 8'h00);
		stream(8'h05, 8'h00, 12);
		stream(8'h05, 8'h01, 6);
		stream(8'h01, 8'h02, 6);
		stream(8'h04, 8'h03, 6);
		stream(8'h05, 8'h04, 9);
		stream(8'h05, 8'h07, 9);
		stream(8'h05, 8'h08, 11);
		stream(8'h05, 8'h0F, 20);
		stream(8'h01, 8'h88, 7);
		wb(1'b0, IDX_STATUS, 8'h00, 1'b1);
		chk(q & 32'h0000_0010, 32'h0000_0010);
		stream(8'h05, 8'h09, 5);
		stream(8'h05, 8'h25, 8);
		stream(8'h05, 8'h16, 8);
		stream(8'h05, 8'h05, 10);
		stream(8'h05, 8'h06, 10);
		chk(32'(nz > 10), 32'h0000_0001);
		tally_and_finish();
	end
endmodule : output_test_pattern_generator_tb_top
